// [hw/srs_supervisor.sv]
// System reset supervisor: request collection, reset sequencing, cause flags and register slave
`timescale 1ns/100ps
// Behaviour
// RL1: In reset, halt core, reload registers, force pins known, disable interrupts and timers.
// RL2: Data memory untouched by reset; stack pointer reinitialised.
// RL3: Port latches load all ones open-drain; weak pull-ups stay enabled.
// RL4: Power-on and supply resets drive the reset pin low throughout reset.
// RL5: On exit, program counter zero, internal oscillator selected, fetch from zero.
// RL6: After any reset watchdog enabled, clocked at system clock over twelve.
// RL7: Power-up holds reset until supply good, then waits the power-on delay.
// RL8: Power-on flag set after power-on reset, cleared by every other reset.
// RL9: Power-on reset enables both supply monitors.
// RL10: Supply below threshold drives pin low and holds core until recovered.
// RL11: Primary monitor enable and selection set only by power-on reset, else kept.
// RL12: Level monitor always enabled and active; no write disables it.
// RL13: Flash write or erase without primary monitor high threshold forces reset.
// RL14: Software enables primary monitor, waits, then selects it as source.
// RL15: Supply-monitor reset releases without the power-on delay.
// RL16: Software writes one to the power-on bit in every cause write.
// RL17: Software should select the high monitor threshold early.
// RL18: Writing software reset bit forces reset; bit reads one; pin undriven.
// RL19: Enabled missing-clock detector resets on stuck clock and flags it.
// RL20: Pin reset flag set on exit from external pin reset.
// RL21: Requests merge into one reset, async assert, sync release, latest cause kept; code: only power-on asserts async, cause fixed at entry.
// RL22: Monitor enable, threshold and source select are independent, kept over resets.
module srs_supervisor
   import srs_pkg::*;
#(
   parameter int POR_DELAY_CYCLES = SRS_POR_DELAY_CYCLES,
   parameter int MCD_CYCLES       = SRS_MCD_CYCLES
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,         // Analogue power-on detector, low while supply absent
   input  wire logic        supply_ok_i,    // Supply above reset threshold (async)
   input  wire logic        rst_pin_i,      // External reset pin level (async)
   input  wire logic        sys_clk_mon_i,  // Monitored system clock level (async)
   input  wire logic        flash_wr_i,     // Flash write or erase attempt strobe
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             core_rst_o,       // Core held, interrupts and timers disabled
   output logic             rst_pin_o,        // Reset pin output value (always low)
   output logic             rst_pin_oe_o,     // Low while driving the pin
   output logic [7:0]       port_latch_o,
   output logic             port_od_o,        // Ports in open-drain mode
   output logic             pullup_en_o,
   output logic             sp_reload_o,      // Stack pointer reload strobe level
   output logic [15:0]      pc_start_o,
   output logic             int_osc_sel_o,
   output logic             wdt_en_o,
   output logic             wdt_tick_o        // One-cycle enable at system clock / 12
);
   // Three-flop synchronisers for pin-side inputs; the pin reads high while we drive it, so our
   // own drive can never hold the supervisor in a pin reset
   logic [2:0] sup_sq, pin_sq, clk_sq;
   logic       sup_ok_q, sup_ok_d, pin_low_q, pin_low_d, mclk_q, mclk_d;
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sup_sq <= 3'h0;
         pin_sq <= 3'h7;
         clk_sq <= 3'h0;
         sup_ok_q  <= 1'b0;
         pin_low_q <= 1'b0;
         mclk_q    <= 1'b0;
      end else begin
         sup_sq <= {sup_sq[1:0], supply_ok_i};
         pin_sq <= {pin_sq[1:0], rst_pin_i || !rst_pin_oe_o};
         clk_sq <= {clk_sq[1:0], sys_clk_mon_i};
         sup_ok_q  <= sup_ok_d;
         pin_low_q <= pin_low_d;
         mclk_q    <= mclk_d;
      end
   end
   // A change counts once the second and third stages agree
   always_comb begin
      sup_ok_d  = (sup_sq[2] == sup_sq[1]) ? sup_sq[2] : sup_ok_q;
      pin_low_d = (pin_sq[2] == pin_sq[1]) ? ~pin_sq[2] : pin_low_q;
      mclk_d    = (clk_sq[2] == clk_sq[1]) ? clk_sq[2] : mclk_q;
   end

   // Control and flag state
   srs_state_e st_q, st_d;
   srs_cause_e cause_q, cause_d;
   logic       mon_en_q, mon_en_d, mon_lvl_q, mon_lvl_d, mon_sel_q, mon_sel_d;
   logic       mcd_en_q, mcd_en_d, sw_req_q, sw_req_d, fl_err_q, fl_err_d;
   logic       drive_pin_q, drive_pin_d, por_pend_q, por_pend_d;
   logic [15:0] dly_q, dly_d;
   logic [15:0] mcd_cnt_q, mcd_cnt_d;
   logic        mclk_prev_q;
   logic [3:0]  wdt_div_q, wdt_div_d;
   logic        mon_fail, mcd_fail, rst_req;
   logic        wr_fire, wr_cause, wr_mon;

   // Missing clock: count cycles without a level change of the monitored clock
   assign mcd_fail = mcd_en_q && (mcd_cnt_q >= MCD_CYCLES[15:0]);  // [RL19]
   // Supply reset ignores primary monitor enable and selection; level monitor always [RL12]
   assign mon_fail = !sup_ok_q;                                     // [RL10] [RL12]
   // Merged request; power-on is the asynchronous reset itself [RL21]
   assign rst_req = mon_fail || pin_low_q || sw_req_q || mcd_fail || fl_err_q;

   always_comb begin
      st_d        = st_q;
      cause_d     = cause_q;
      mon_en_d    = mon_en_q;
      mon_lvl_d   = mon_lvl_q;
      mon_sel_d   = mon_sel_q;
      mcd_en_d    = mcd_en_q;
      sw_req_d    = 1'b0;
      fl_err_d    = fl_err_q;
      drive_pin_d = drive_pin_q;
      por_pend_d  = por_pend_q;
      dly_d       = dly_q;
      mcd_cnt_d   = (mclk_q != mclk_prev_q || st_q != SRS_ST_RUN) ? 16'h0000 : mcd_cnt_q + 16'h0001;
      wdt_div_d   = (wdt_div_q == 4'(SRS_WDT_DIV - 1)) ? 4'h0 : wdt_div_q + 4'h1;
      // Flash write with unsafe monitor setting [RL13]
      if (flash_wr_i && st_q == SRS_ST_RUN && !(mon_en_q && mon_lvl_q)) begin
         fl_err_d = 1'b1;
      end
      // Register writes steer the supervisor
      if (wr_fire && wr_cause && st_q == SRS_ST_RUN) begin
         mon_sel_d = wd_q[SRS_CAUSE_POR_BIT];                        // [RL22]
         mcd_en_d  = wd_q[SRS_CAUSE_MCD_BIT];
         sw_req_d  = wd_q[SRS_CAUSE_SW_BIT];                         // [RL18]
      end
      if (wr_fire && wr_mon && st_q == SRS_ST_RUN) begin
         mon_en_d  = wd_q[SRS_MON_EN_BIT];                           // [RL22]
         mon_lvl_d = wd_q[SRS_MON_LVL_BIT];
      end
      case (st_q)
         SRS_ST_RUN: begin
            if (rst_req) begin
               st_d = SRS_ST_HOLD;
               // Supply resets drive the pin, others leave it undriven [RL4] [RL18]
               drive_pin_d = mon_fail;
               fl_err_d    = fl_err_d && !fl_err_q;  // A fresh attempt in this cycle counts unless fl_err_q is already set
               mcd_en_d    = 1'b0;
               if (mon_fail)       cause_d = SRS_C_MON;
               else if (fl_err_q)  cause_d = SRS_C_FLERR;
               else if (mcd_fail)  cause_d = SRS_C_MCD;
               else if (sw_req_q)  cause_d = SRS_C_SW;
               else                cause_d = SRS_C_PIN;
            end
         end
         SRS_ST_HOLD: begin
            dly_d = 16'h0000;
            if (!mon_fail && !pin_low_q) begin
               // Only the power-up path waits the release delay [RL7] [RL15]
               st_d = por_pend_q ? SRS_ST_DELAY : SRS_ST_RUN;
               drive_pin_d = por_pend_q;
            end else if (mon_fail) begin
               drive_pin_d = 1'b1;                                   // [RL10]
            end
         end
         SRS_ST_DELAY: begin
            dly_d = dly_q + 16'h0001;
            if (mon_fail) begin
               st_d = SRS_ST_HOLD;
            end else if (dly_q >= 16'(POR_DELAY_CYCLES - 1)) begin   // [RL7]
               st_d        = SRS_ST_RUN;
               por_pend_d  = 1'b0;
               drive_pin_d = 1'b0;
            end
         end
         default: st_d = SRS_ST_HOLD;
      endcase
   end

   // Power-on values: both monitors enabled and selected, power-on cause [RL9] [RL11]
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q        <= SRS_ST_HOLD;
         cause_q     <= SRS_C_POR;                                   // [RL8]
         mon_en_q    <= 1'b1;
         mon_lvl_q   <= 1'b0;
         mon_sel_q   <= 1'b1;
         mcd_en_q    <= 1'b0;
         sw_req_q    <= 1'b0;
         fl_err_q    <= 1'b0;
         drive_pin_q <= 1'b1;                                        // [RL4]
         por_pend_q  <= 1'b1;
         dly_q       <= 16'h0000;
         mcd_cnt_q   <= 16'h0000;
         mclk_prev_q <= 1'b0;
         wdt_div_q   <= 4'h0;
      end else begin
         st_q        <= st_d;
         cause_q     <= cause_d;
         mon_en_q    <= mon_en_d;
         mon_lvl_q   <= mon_lvl_d;
         mon_sel_q   <= mon_sel_d;
         mcd_en_q    <= mcd_en_d;
         sw_req_q    <= sw_req_d;
         fl_err_q    <= fl_err_d;
         drive_pin_q <= drive_pin_d;
         por_pend_q  <= por_pend_d;
         dly_q       <= dly_d;
         mcd_cnt_q   <= mcd_cnt_d;
         mclk_prev_q <= mclk_q;
         wdt_div_q   <= wdt_div_d;
      end
   end

   // Core-facing outputs, registered; memory is never touched here [RL2]
   logic in_rst;
   assign in_rst = (st_d != SRS_ST_RUN);
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         core_rst_o    <= 1'b1;
         rst_pin_oe_o  <= 1'b0;
         sp_reload_o   <= 1'b1;
         wdt_tick_o    <= 1'b0;
      end else begin
         core_rst_o    <= in_rst;                                    // [RL1] [RL21]
         rst_pin_oe_o  <= !drive_pin_d;                              // [RL4]
         sp_reload_o   <= in_rst;                                    // [RL2]
         wdt_tick_o    <= !in_rst && (wdt_div_q == 4'h0);            // [RL6]
      end
   end
   // Constant outputs still from flops, per house style
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_pin_o     <= 1'b0;
         port_latch_o  <= SRS_PORT_LATCH_RST;                        // [RL3]
         port_od_o     <= 1'b1;
         pullup_en_o   <= 1'b1;
         pc_start_o    <= SRS_PC_RST;                                // [RL5]
         int_osc_sel_o <= 1'b1;
         wdt_en_o      <= 1'b1;
      end else begin
         rst_pin_o     <= 1'b0;
         port_latch_o  <= SRS_PORT_LATCH_RST;
         port_od_o     <= 1'b1;
         pullup_en_o   <= 1'b1;
         pc_start_o    <= SRS_PC_RST;
         int_osc_sel_o <= 1'b1;
         wdt_en_o      <= 1'b1;                                      // [RL6]
      end
   end

   // AXI4-Lite slave: write taken when address and data both present
   logic aw_q, w_q;
   logic [3:0] awa_q;
   logic [31:0] wd_q;
   assign wr_fire  = aw_q && w_q && !s_axi_bvalid;
   assign wr_cause = (awa_q == SRS_CAUSE_OFF);
   assign wr_mon   = (awa_q == SRS_MON_CTRL_OFF);
   logic [31:0] rd_val;
   logic [7:0]  cause_bits;
   always_comb begin
      cause_bits = 8'h80;
      case (cause_q)
         SRS_C_POR:   cause_bits[SRS_CAUSE_POR_BIT] = 1'b1;          // [RL8]
         SRS_C_PIN:   cause_bits[SRS_CAUSE_PIN_BIT] = 1'b1;          // [RL20]
         SRS_C_SW:    cause_bits[SRS_CAUSE_SW_BIT]  = 1'b1;          // [RL18]
         SRS_C_MCD:   cause_bits[SRS_CAUSE_MCD_BIT] = 1'b1;          // [RL19]
         SRS_C_FLERR: cause_bits[SRS_CAUSE_FLERR_BIT] = 1'b1;
         default:     cause_bits = 8'h80;
      endcase
      case (s_axi_araddr[3:0])
         SRS_MON_CTRL_OFF: rd_val = {24'h0, mon_en_q, sup_ok_q, mon_lvl_q, 1'b1, 4'h0};
         SRS_CAUSE_OFF:    rd_val = {24'h0, cause_bits};
         SRS_CORE_OFF:     rd_val = {30'h0, mon_sel_q, mcd_en_q};
         default:          rd_val = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_q <= 1'b0;
         w_q  <= 1'b0;
         awa_q <= 4'h0;
         wd_q <= 32'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_awready <= !aw_q && s_axi_awvalid && !s_axi_awready;
         s_axi_wready  <= !w_q && s_axi_wvalid && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awa_q <= s_axi_awaddr[3:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wd_q <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_cause || wr_mon) ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= (s_axi_araddr[3:0] <= SRS_CORE_OFF && s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : srs_supervisor

// [common/srs_pkg.sv]
// Package for the system reset supervisor: register map, fields, reset values and timing
package srs_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [3:0] SRS_MON_CTRL_OFF = 4'h0;   // Supply monitor control and status
   localparam logic [3:0] SRS_CAUSE_OFF    = 4'h4;   // Reset cause register
   localparam logic [3:0] SRS_CORE_OFF     = 4'h8;   // Core state view after reset
   // Monitor control fields
   localparam int SRS_MON_EN_BIT     = 7;
   localparam int SRS_MON_STAT_BIT   = 6;
   localparam int SRS_MON_LVL_BIT    = 5;
   localparam int SRS_MON1_EN_BIT    = 4;
   // Reset cause fields
   localparam int SRS_CAUSE_FLERR_BIT = 6;
   localparam int SRS_CAUSE_SW_BIT    = 4;
   localparam int SRS_CAUSE_MCD_BIT   = 2;
   localparam int SRS_CAUSE_POR_BIT   = 1;
   localparam int SRS_CAUSE_PIN_BIT   = 0;
   // Values after reset
   localparam logic [7:0]  SRS_PORT_LATCH_RST = 8'hFF;
   localparam logic [15:0] SRS_PC_RST         = 16'h0000;
   localparam logic [7:0]  SRS_SP_RST         = 8'h07;
   // Timing
   localparam int SRS_CLK_HZ            = 10_000_000;
   localparam int SRS_MCD_TIMEOUT_US    = 100;
   localparam int SRS_MCD_CYCLES        = SRS_MCD_TIMEOUT_US * (SRS_CLK_HZ / 1_000_000);
   localparam int SRS_POR_DELAY_US      = 100;
   localparam int SRS_POR_DELAY_CYCLES  = SRS_POR_DELAY_US * (SRS_CLK_HZ / 1_000_000);
   localparam int SRS_WDT_DIV           = 12;
   // Supervisor states
   typedef enum logic [2:0] {
      SRS_ST_HOLD  = 3'b001,
      SRS_ST_DELAY = 3'b010,
      SRS_ST_RUN   = 3'b100
   } srs_state_e;
   // Cause codes recorded at entry to reset
   typedef enum logic [2:0] {
      SRS_C_POR = 3'h0, SRS_C_MON = 3'h1, SRS_C_PIN = 3'h2, SRS_C_SW = 3'h3,
      SRS_C_MCD = 3'h4, SRS_C_FLERR = 3'h5
   } srs_cause_e;
endpackage : srs_pkg

// [test/srs_supervisor_asserts.sv]
// Port-level checker for the system reset supervisor
`timescale 1ns/100ps
module srs_supervisor_asserts #(
   parameter int POR_DELAY_CYCLES = 8
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        supply_ok_i,
   input  wire logic        core_rst_o,
   input  wire logic        rst_pin_o,
   input  wire logic        rst_pin_oe_o,
   input  wire logic [7:0]  port_latch_o,
   input  wire logic        port_od_o,
   input  wire logic        pullup_en_o,
   input  wire logic        sp_reload_o,
   input  wire logic [15:0] pc_start_o,
   input  wire logic        int_osc_sel_o,
   input  wire logic        wdt_en_o,
   input  wire logic        wdt_tick_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   logic       ran_q;      // Core has run since power-on
   int         por_cnt_q;  // Cycles from power-on release to first run
   logic [3:0] gap_q;      // Cycles since last watchdog tick
   logic       seen_q;     // A tick was seen in this run
   // Helper counters; the tick spacing only counts inside one run, so a reset restarts it
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ran_q     <= 1'b0;
         por_cnt_q <= 0;
         gap_q     <= 4'h0;
         seen_q    <= 1'b0;
      end else begin
         ran_q     <= ran_q | !core_rst_o;
         por_cnt_q <= ran_q ? por_cnt_q : por_cnt_q + 1;
         gap_q     <= wdt_tick_o ? 4'h0 : (core_rst_o ? gap_q : gap_q + 4'h1);
         seen_q    <= wdt_tick_o | (seen_q & !core_rst_o);
      end
   end
   property p_pin_low; !rst_pin_o; endproperty
   a_pin_low: assert property (p_pin_low) else $error("reset pin driven high");
   property p_pin_rel; $fell(core_rst_o) |-> ##[0:1] rst_pin_oe_o; endproperty
   a_pin_rel: assert property (p_pin_rel) else $error("pin still driven after exit");
   property p_sp; sp_reload_o == core_rst_o; endproperty
   a_sp: assert property (p_sp) else $error("stack reload not tied to reset");
   property p_ports; port_latch_o == 8'hFF && port_od_o && pullup_en_o; endproperty
   a_ports: assert property (p_ports) else $error("port state wrong");
   property p_exit; $fell(core_rst_o) |-> pc_start_o == 16'h0000 && int_osc_sel_o && wdt_en_o; endproperty
   a_exit: assert property (p_exit) else $error("exit state wrong");
   property p_wdt_per; wdt_tick_o && seen_q && !core_rst_o |-> gap_q == 4'hB; endproperty
   a_wdt_per: assert property (p_wdt_per) else $error("watchdog tick period wrong");
   property p_wdt_gap; seen_q && !core_rst_o |-> gap_q <= 4'hB; endproperty
   a_wdt_gap: assert property (p_wdt_gap) else $error("watchdog tick missing");
   property p_por_dly; $fell(core_rst_o) && !ran_q |-> por_cnt_q >= POR_DELAY_CYCLES; endproperty
   a_por_dly: assert property (p_por_dly) else $error("power-on delay too short");
   property p_sup_rst; $fell(supply_ok_i) |-> ##[1:5] (core_rst_o && !rst_pin_oe_o); endproperty
   a_sup_rst: assert property (p_sup_rst) else $error("supply drop not reset");
   property p_sup_hold; (!supply_ok_i)[*6] |-> core_rst_o && !rst_pin_oe_o; endproperty
   a_sup_hold: assert property (p_sup_hold) else $error("core left reset while supply low");
   property p_fast_rel; ran_q && $rose(supply_ok_i) |-> ##[1:8] !core_rst_o; endproperty
   a_fast_rel: assert property (p_fast_rel) else $error("slow release after supply reset");
endmodule : srs_supervisor_asserts
bind srs_supervisor srs_supervisor_asserts #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES)) i_srs_supervisor_asserts (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .supply_ok_i(supply_ok_i), .core_rst_o(core_rst_o),
   .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o), .port_latch_o(port_latch_o), .port_od_o(port_od_o),
   .pullup_en_o(pullup_en_o), .sp_reload_o(sp_reload_o), .pc_start_o(pc_start_o),
   .int_osc_sel_o(int_osc_sel_o), .wdt_en_o(wdt_en_o), .wdt_tick_o(wdt_tick_o));

// [test/srs_far_side_model.sv]
// Supply monitor output, reset pin wire and system clock seen by the supervisor
`timescale 1ns/100ps
module srs_far_side_model (
   input  wire logic ref_clk_i,
   input  wire logic supply_good_i,  // Bench command: supply above threshold
   input  wire logic pin_press_i,    // Bench command: external circuit pulls pin low
   input  wire logic clk_stop_i,     // Bench command: system clock stuck
   input  wire logic drv_val_i,
   input  wire logic drv_oe_n_i,
   output logic      supply_ok_o,
   output logic      pin_lvl_o,
   output logic      sys_clk_o
);
   // Pin has a pull-up, so it floats high unless a party pulls it low
   assign pin_lvl_o   = !pin_press_i && (drv_oe_n_i || drv_val_i);
   assign supply_ok_o = supply_good_i;
   // Clock toggles every second cycle unless stuck; slower than the sampling so the filter passes it
   logic ph_q;
   initial sys_clk_o = 1'b0;
   initial ph_q = 1'b0;
   always @(posedge ref_clk_i) begin
      ph_q <= !ph_q;
      if (!clk_stop_i && ph_q) sys_clk_o <= !sys_clk_o;
   end
endmodule : srs_far_side_model

// [test/system_reset_supervisor_test.sv]
// Self-checking bench for the system reset supervisor
`timescale 1ns/100ps
module system_reset_supervisor_test;
   import srs_pkg::*;
   localparam int POR_DLY = 40;
   logic ref_clk_i, rstn_i, supply_ok_i, rst_pin_i, sys_clk_mon_i, flash_wr_i;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, core_rst_o, rst_pin_o, rst_pin_oe_o;
   logic port_od_o, pullup_en_o, int_osc_sel_o, wdt_en_o, supply_good, pin_press, clk_stop;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d, v;
   logic [15:0] pc_start_o;
   logic [7:0]  port_latch_o;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   int          failures, checks_done, cycles, seed, n;
   srs_supervisor #(.POR_DELAY_CYCLES(POR_DLY), .MCD_CYCLES(8)) i_srs_supervisor (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .supply_ok_i(supply_ok_i), .rst_pin_i(rst_pin_i),
      .sys_clk_mon_i(sys_clk_mon_i), .flash_wr_i(flash_wr_i), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .core_rst_o(core_rst_o), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
      .port_latch_o(port_latch_o), .port_od_o(port_od_o), .pullup_en_o(pullup_en_o), .sp_reload_o(),
      .pc_start_o(pc_start_o), .int_osc_sel_o(int_osc_sel_o), .wdt_en_o(wdt_en_o), .wdt_tick_o());
   srs_far_side_model i_srs_far_side_model (
      .ref_clk_i(ref_clk_i), .supply_good_i(supply_good), .pin_press_i(pin_press), .clk_stop_i(clk_stop),
      .drv_val_i(rst_pin_o), .drv_oe_n_i(rst_pin_oe_o), .supply_ok_o(supply_ok_i), .pin_lvl_o(rst_pin_i),
      .sys_clk_o(sys_clk_mon_i));
   // 10 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   // Hang guard well above the few hundred cycles the sequence needs
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end
   function automatic logic [31:0] exp_mon(input logic en, input logic lvl);
      return {24'h0, en, 1'b1, lvl, 5'h10};
   endfunction : exp_mon
   function automatic logic [31:0] exp_cause(input logic [7:0] b);
      return {24'h0, 8'h80 | b};
   endfunction : exp_cause
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      s_axi_awaddr <= {28'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk_i);
      s_axi_araddr <= {28'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd_d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_d, exp);
   endtask : rdc
   // Bounded wait for the core reset to reach a level; n holds the cycles taken
   task automatic wait_lvl(input logic l);
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (core_rst_o !== l && n < 600);
      if (core_rst_o !== l) failures++;
   endtask : wait_lvl
   task automatic flash_try();
      @(posedge ref_clk_i);
      flash_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      flash_wr_i <= 1'b0;
   endtask : flash_try
   // Main sequence
   initial begin
      {failures, checks_done, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd91325};
      {rstn_i, flash_wr_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hF;
      {supply_good, pin_press, clk_stop} = 3'b100;
      repeat (10) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      @(posedge ref_clk_i);
      #1 chk({core_rst_o, rst_pin_oe_o}, 2'b10);
      wait_lvl(1'b0);
      chk(n >= POR_DLY, 1'b1);
      rdc(SRS_CAUSE_OFF, exp_cause(8'h02));
      rdc(SRS_MON_CTRL_OFF, exp_mon(1'b1, 1'b0));
      rdc(SRS_CORE_OFF, 32'h2);
      chk({port_latch_o, port_od_o, pullup_en_o, pc_start_o, int_osc_sel_o, wdt_en_o},
          {SRS_PORT_LATCH_RST, 2'b11, SRS_PC_RST, 2'b11});
      rd(4'hC);
      chk({rsp, rd_d[29:0]}, 32'h80000000);
      wr(4'hC, 32'hFF);
      chk(rsp, 2'b10);
      // Random enable and threshold writes; level monitor bit never clears
      for (int i = 0; i < 8; i++) begin
         v = $random(seed);
         wr(SRS_MON_CTRL_OFF, v & 32'hFF);
         rdc(SRS_MON_CTRL_OFF, exp_mon(v[7], v[5]));
      end
      wr(SRS_MON_CTRL_OFF, 32'h80);
      flash_try();
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      rdc(SRS_CAUSE_OFF, exp_cause(8'h40));
      rdc(SRS_MON_CTRL_OFF, exp_mon(1'b1, 1'b0));
      wr(SRS_MON_CTRL_OFF, 32'hA0);
      flash_try();
      repeat (20) @(posedge ref_clk_i);
      chk(core_rst_o, 1'b0);
      wr(SRS_MON_CTRL_OFF, 32'h20);
      wr(SRS_CAUSE_OFF, 32'h12);
      wait_lvl(1'b1);
      #1 chk(rst_pin_oe_o, 1'b1);
      wait_lvl(1'b0);
      rdc(SRS_CAUSE_OFF, exp_cause(8'h10));
      rdc(SRS_MON_CTRL_OFF, exp_mon(1'b0, 1'b1));
      rdc(SRS_CORE_OFF, 32'h2);
      wr(SRS_MON_CTRL_OFF, 32'hA0);
      repeat (20) @(posedge ref_clk_i);
      wr(SRS_CAUSE_OFF, 32'h06);
      rdc(SRS_CORE_OFF, 32'h3);
      clk_stop <= 1'b1;
      wait_lvl(1'b1);
      clk_stop <= 1'b0;
      wait_lvl(1'b0);
      rdc(SRS_CAUSE_OFF, exp_cause(8'h04));
      rdc(SRS_CORE_OFF, 32'h2);
      pin_press <= 1'b1;
      wait_lvl(1'b1);
      pin_press <= 1'b0;
      wait_lvl(1'b0);
      rdc(SRS_CAUSE_OFF, exp_cause(8'h01));
      supply_good <= 1'b0;
      wait_lvl(1'b1);
      #1 chk(rst_pin_oe_o, 1'b0);
      repeat (10) @(posedge ref_clk_i);
      supply_good <= 1'b1;
      wait_lvl(1'b0);
      chk(n < POR_DLY, 1'b1);
      rdc(SRS_CAUSE_OFF, exp_cause(8'h00));
      final_report();
   end
endmodule : system_reset_supervisor_test
